/* hw/flash_sec_regs.svh */
// Purpose: constants for the security register host controller
// Assumes: word mode bus, 20 MHz clock
// Notes: offsets are word addresses on the flash address pins
// Notes on behaviour
// - user half written only by four-cycle register program sequence
// - lock uses four-cycle command, fourth data with lock_bit zero
// - read register after ident_mode_entry using ordinary reads
// - host issues ident_mode_exit before any other operation
// - query-table entry is one write of 98h to address 55h
// - query-table mode ends only with ident_mode_exit
// - host rereads polling or toggle bit after fail_bit is seen; host waits on the completion line instead
// - host drives upper address lines to zero for register access
`ifndef FLASH_SEC_REGS_SVH
`define FLASH_SEC_REGS_SVH
`define ADDR_UNLOCK1 12'h555
`define ADDR_UNLOCK2 12'h2aa
`define ADDR_QUERY 12'h055
`define ADDR_LOCK 12'h080
`define ADDR_SEC_BASE 12'h081
`define ADDR_USER_BASE 12'h085
`define DATA_UNLOCK1 8'haa
`define DATA_UNLOCK2 8'h55
`define CMD_IDENT_ENTRY 8'h90
`define CMD_IDENT_EXIT 8'hf0
`define CMD_SEC_PROG 8'hc0
`define CMD_QUERY 8'h98
`define CMD_LOCK_DATA 8'hfd
`define LOCK_BIT_POS 1
`define POLL_BIT_POS 7
`define TOGGLE_BIT_POS 6
`define FAIL_BIT_POS 5
`define SEC_WORDS 8
`define T_POWERUP_US 10000
`define CLK_MHZ 20
`define POWERUP_CYCLES (`T_POWERUP_US * `CLK_MHZ)
`define BUS_PHASE_CYCLES 2
`endif

/* hw/flash_sec_pkg.sv */
package flash_sec_pkg;
    typedef enum logic [2:0] {
        OP_READ_SEC,
        OP_PROG_USER,
        OP_LOCK_USER,
        OP_LOCK_QUERY,
        OP_QUERY_ENTRY,
        OP_EXIT,
        OP_EXIT_SHORT
    } op_t;
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_SETUP,
        CYC_STROBE,
        CYC_HOLD
    } cyc_t;
endpackage

/* hw/flash_bus_cycle.sv */
// Purpose: one write or read cycle on the flash parallel bus
// Assumes: one phase of BUS_PHASE_CYCLES clocks covers access times
// Notes: data pins are split into in, out and output enable
`timescale 1ns/1ps
`include "flash_sec_regs.svh"
module flash_bus_cycle
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // flash pins
    output logic [18:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    input wire logic [15:0] fl_dq_in,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe_n
);
    ////////////////////////////////////////////////////////////////////
    flash_sec_pkg::cyc_t st_r;
    logic [3:0] cnt_r;
    logic wr_r;
    logic phase_end;
    assign phase_end = cnt_r == 4'(`BUS_PHASE_CYCLES - 1);
    assign done = st_r == flash_sec_pkg::CYC_HOLD && phase_end;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= flash_sec_pkg::CYC_IDLE;
            cnt_r <= 4'h0;
        end
        else if (st_r == flash_sec_pkg::CYC_IDLE)
        begin
            cnt_r <= 4'h0;
            if (start)
                st_r <= flash_sec_pkg::CYC_SETUP;
        end
        else if (phase_end)
        begin
            cnt_r <= 4'h0;
            case (st_r)
                flash_sec_pkg::CYC_SETUP: st_r <= flash_sec_pkg::CYC_STROBE;
                flash_sec_pkg::CYC_STROBE: st_r <= flash_sec_pkg::CYC_HOLD;
                default: st_r <= flash_sec_pkg::CYC_IDLE;
            endcase
        end
        else
            cnt_r <= cnt_r + 4'h1;
    end
    // upper lines stay zero on every access
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fl_addr <= 19'h0;
            fl_dq_out <= 16'h0;
            wr_r <= 1'b0;
        end
        else if (start && st_r == flash_sec_pkg::CYC_IDLE)
        begin
            fl_addr <= {7'h0, addr};
            fl_dq_out <= wdata;
            wr_r <= wr;
        end
    end
    // oe held high while we strobes, so a write is never inhibited
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_dq_oe_n <= 1'b1;
        end
        else
        begin
            fl_ce_n <= !(st_r != flash_sec_pkg::CYC_IDLE && !done);
            fl_we_n <= !(wr_r && st_r == flash_sec_pkg::CYC_SETUP
                && phase_end);
            if (st_r == flash_sec_pkg::CYC_STROBE && !phase_end)
                fl_we_n <= !wr_r;
            fl_oe_n <= !(!wr_r && (st_r == flash_sec_pkg::CYC_STROBE
                || (st_r == flash_sec_pkg::CYC_SETUP && phase_end)));
            fl_dq_oe_n <= !(wr_r && st_r != flash_sec_pkg::CYC_IDLE
                && !done);
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 16'h0;
        else if (st_r == flash_sec_pkg::CYC_STROBE && phase_end)
            rdata <= fl_dq_in;
    end
endmodule

/* hw/flash_sec_host.sv */
// Purpose: host sequencer for the flash security register commands
// Assumes: word mode, device idle in read mode when a command starts
// Notes: status decoding of the data bits is left to the user
`timescale 1ns/1ps
`include "flash_sec_regs.svh"
module flash_sec_host
#(
    parameter int POWERUP_CYCLES = `POWERUP_CYCLES
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // user command port
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [1:0] CMD_WORD,
    input wire logic [15:0] CMD_DATA,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic RSP_LOCKED,
    output logic [127:0] SEC_DATA,
    // device status
    input wire logic READY_BUSY_IN,
    output logic DEV_BUSY,
    // flash pins
    output logic [18:0] FL_ADDR,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    input wire logic [15:0] FL_DQ_IN,
    output logic [15:0] FL_DQ_OUT,
    output logic FL_DQ_OE_N
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        S_WAIT_PWR,
        S_IDLE,
        S_ISSUE,
        S_BUSY,
        S_DONE
    } state_t;
    state_t st_r;
    flash_sec_pkg::op_t op_r;
    logic [31:0] pwr_cnt_r;
    logic [3:0] step_r;
    logic [3:0] nsteps;
    logic [1:0] word_r;
    logic [15:0] data_r;
    logic bc_start;
    logic bc_wr;
    logic [11:0] bc_addr;
    logic [15:0] bc_wdata;
    logic bc_done;
    logic [15:0] bc_rdata;
    logic [127:0] sec_r;
    logic [2:0] rd_idx_r;

    // unlock prefix shared by every multi-cycle command
    function automatic logic [27:0] unlock(input logic [3:0] s,
        input logic [7:0] cmd);
        case (s)
            4'h0: unlock = {`ADDR_UNLOCK1, 8'h00, `DATA_UNLOCK1};
            4'h1: unlock = {`ADDR_UNLOCK2, 8'h00, `DATA_UNLOCK2};
            default: unlock = {`ADDR_UNLOCK1, 8'h00, cmd};
        endcase
    endfunction

    // sequence length per operation
    always_comb
    begin
        case (op_r)
            flash_sec_pkg::OP_READ_SEC: nsteps = 4'd3 + 4'(`SEC_WORDS) + 4'd1;
            flash_sec_pkg::OP_QUERY_ENTRY: nsteps = 4'd1;
            flash_sec_pkg::OP_EXIT_SHORT: nsteps = 4'd1;
            flash_sec_pkg::OP_EXIT: nsteps = 4'd3;
            flash_sec_pkg::OP_LOCK_QUERY: nsteps = 4'd5;
            default: nsteps = 4'd4;
        endcase
    end

    // per-step address, data and direction
    always_comb
    begin
        bc_wr = 1'b1;
        bc_addr = `ADDR_UNLOCK1;
        bc_wdata = 16'h0;
        case (op_r)
            flash_sec_pkg::OP_QUERY_ENTRY:
            begin
                {bc_addr, bc_wdata} = {`ADDR_QUERY, 8'h00, `CMD_QUERY};
            end
            flash_sec_pkg::OP_EXIT_SHORT:
            begin
                // one-cycle exit form
                bc_wdata = {8'h00, `CMD_IDENT_EXIT};
            end
            flash_sec_pkg::OP_EXIT:
            begin
                {bc_addr, bc_wdata} = unlock(step_r, `CMD_IDENT_EXIT);
            end
            flash_sec_pkg::OP_PROG_USER:
            begin
                {bc_addr, bc_wdata} = unlock(step_r, `CMD_SEC_PROG);
                if (step_r == 4'h3)
                begin
                    // user half words only, factory half never written
                    bc_addr = `ADDR_USER_BASE + {10'h0, word_r};
                    bc_wdata = data_r;
                end
            end
            flash_sec_pkg::OP_LOCK_USER:
            begin
                {bc_addr, bc_wdata} = unlock(step_r, `CMD_SEC_PROG);
                if (step_r == 4'h3)
                begin
                    bc_addr = `ADDR_LOCK;
                    bc_wdata = {8'h00, `CMD_LOCK_DATA}; // lock_bit zero
                end
            end
            flash_sec_pkg::OP_LOCK_QUERY:
            begin
                {bc_addr, bc_wdata} = unlock(step_r, `CMD_IDENT_ENTRY);
                if (step_r == 4'h3)
                begin
                    bc_wr = 1'b0;
                    bc_addr = `ADDR_LOCK;
                end
                else if (step_r == 4'h4)
                    bc_wdata = {8'h00, `CMD_IDENT_EXIT};
            end
            flash_sec_pkg::OP_READ_SEC:
            begin
                {bc_addr, bc_wdata} = unlock(step_r, `CMD_IDENT_ENTRY);
                if (step_r == 4'(3 + `SEC_WORDS))
                    bc_wdata = {8'h00, `CMD_IDENT_EXIT};
                else if (step_r >= 4'h3)
                begin
                    bc_wr = 1'b0;
                    bc_addr = `ADDR_SEC_BASE + {9'h0, rd_idx_r};
                end
            end
            default: bc_wr = 1'b1;
        endcase
    end

    assign bc_start = st_r == S_ISSUE;
    assign CMD_READY = st_r == S_IDLE;
    // completion line low means a device program cycle runs
    assign DEV_BUSY = !READY_BUSY_IN;

    ////////////////////////////////////////////////////////////////////
    // no command until the power-on programming delay expires
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            pwr_cnt_r <= 32'h0;
        else if (st_r == S_WAIT_PWR)
            pwr_cnt_r <= pwr_cnt_r + 32'h1;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            st_r <= S_WAIT_PWR;
            op_r <= flash_sec_pkg::OP_EXIT_SHORT;
            step_r <= 4'h0;
            word_r <= 2'h0;
            data_r <= 16'h0;
        end
        else
        begin
            case (st_r)
                S_WAIT_PWR:
                    if (pwr_cnt_r >= 32'(POWERUP_CYCLES))
                        st_r <= S_IDLE;
                S_IDLE:
                    if (CMD_VALID)
                    begin
                        op_r <= flash_sec_pkg::op_t'(CMD_OP);
                        word_r <= CMD_WORD;
                        data_r <= CMD_DATA;
                        step_r <= 4'h0;
                        st_r <= S_ISSUE;
                    end
                S_ISSUE:
                    st_r <= S_BUSY;
                S_BUSY:
                    if (bc_done)
                    begin
                        if (step_r == nsteps - 4'h1)
                            st_r <= S_DONE;
                        else
                        begin
                            step_r <= step_r + 4'h1;
                            st_r <= S_ISSUE;
                        end
                    end
                S_DONE:
                    // completion line, not status bits: no fail_bit race
                    if (READY_BUSY_IN)
                        st_r <= S_IDLE;
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // read index walks the eight register words
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || st_r == S_IDLE)
            rd_idx_r <= 3'h0;
        else if (st_r == S_BUSY && bc_done && !bc_wr
            && op_r == flash_sec_pkg::OP_READ_SEC)
            rd_idx_r <= rd_idx_r + 3'h1;
    end

    // words 0..3 factory half, 4..7 user half
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            sec_r <= 128'h0;
        else if (st_r == S_BUSY && bc_done && !bc_wr
            && op_r == flash_sec_pkg::OP_READ_SEC)
            sec_r[rd_idx_r * 16 +: 16] <= bc_rdata;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 16'h0;
            RSP_LOCKED <= 1'b0;
        end
        else
        begin
            RSP_VALID <= st_r == S_DONE && READY_BUSY_IN;
            if (st_r == S_BUSY && bc_done && !bc_wr)
            begin
                RSP_DATA <= bc_rdata;
                if (op_r == flash_sec_pkg::OP_LOCK_QUERY)
                    RSP_LOCKED <= !bc_rdata[`LOCK_BIT_POS];
            end
        end
    end
    assign SEC_DATA = sec_r;

    flash_bus_cycle u_cycle
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .start(bc_start),
        .wr(bc_wr),
        .addr(bc_addr),
        .wdata(bc_wdata),
        .done(bc_done),
        .rdata(bc_rdata),
        .fl_addr(FL_ADDR),
        .fl_ce_n(FL_CE_N),
        .fl_oe_n(FL_OE_N),
        .fl_we_n(FL_WE_N),
        .fl_dq_in(FL_DQ_IN),
        .fl_dq_out(FL_DQ_OUT),
        .fl_dq_oe_n(FL_DQ_OE_N)
    );
endmodule

/* verif/flash_sec_host_asserts.sv */
// Purpose: port checks for the security register host
// Assumes: POWERUP_CYCLES of at least 7
// Notes: bound to every flash_sec_host instance
`timescale 1ns/1ps
module flash_sec_host_asserts
#(
    parameter int POWERUP_CYCLES = 10
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // user side
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire logic RSP_VALID,
    // device side
    input wire logic READY_BUSY_IN,
    input wire logic DEV_BUSY,
    input wire logic [18:0] FL_ADDR,
    input wire logic FL_CE_N,
    input wire logic FL_OE_N,
    input wire logic FL_WE_N,
    input wire logic FL_DQ_OE_N
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
////////////////////////////////////////////////////////////////////////////
    a_upper_addr_zero: assert property (FL_ADDR[18:12] == 7'h00)
        else $error("upper address lines not zero");
    a_we_needs_ce: assert property (!FL_WE_N |-> !FL_CE_N)
        else $error("write strobe without chip enable");
    a_we_not_oe: assert property (!FL_WE_N |-> FL_OE_N)
        else $error("write strobe while output enabled");
    a_drive_not_read: assert property (!FL_DQ_OE_N |-> FL_OE_N)
        else $error("host drives data during a read");
    a_we_two_clk: assert property (
        $fell(FL_WE_N) |=> !FL_WE_N ##1 FL_WE_N)
        else $error("write strobe not two clocks wide");
    a_busy_mirror: assert property (DEV_BUSY == !READY_BUSY_IN)
        else $error("busy flag does not mirror completion line");
    a_rsp_after_ready: assert property (
        RSP_VALID |-> $past(READY_BUSY_IN) && !$stable(RSP_VALID))
        else $error("response while device busy");
    a_rsp_one_pulse: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("response pulse longer than one clock");
    a_powerup_wait: assert property (
        $fell(SYS_RST) |-> !CMD_READY [*8])
        else $error("request accepted before power-up wait");
    a_one_op_at_once: assert property (
        CMD_VALID && CMD_READY |=> !CMD_READY)
        else $error("second request accepted mid operation");
endmodule

bind flash_sec_host flash_sec_host_asserts
    #(.POWERUP_CYCLES(POWERUP_CYCLES))
    flash_sec_host_asserts_inst
(
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
    .READY_BUSY_IN(READY_BUSY_IN), .DEV_BUSY(DEV_BUSY),
    .FL_ADDR(FL_ADDR), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
    .FL_WE_N(FL_WE_N), .FL_DQ_OE_N(FL_DQ_OE_N)
);

/* verif/flash_dev_model.sv */
// Purpose: behavioural flash device, security register part only
// Assumes: word mode, commands decoded when write strobe ends
// Notes: released bus shows inverse of last read, no pull
`timescale 1ns/1ps
module flash_dev_model
#(
    parameter logic [63:0] FACTORY = 64'h5a3c96e10f872b4d, // arbitrary
    parameter int PWR_CLKS = 6
)
(
    // clock, power and pacing
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] busy_len,
    // flash pins
    input wire logic [18:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] dq,
    output logic [15:0] dq_out,
    output logic rdy
);
    logic [15:0] user_r [4];
    logic [15:0] rd, held_r, last_r;
    logic locked_r, ident_r, query_r, prog_r, we_q, oe_q, tog_r;
    logic [1:0] step_r;
    logic [7:0] busy_r, a, d;
    logic wr_e, s555;
    int pwr_r;
    assign a = addr[7:0];
    assign d = dq[7:0];
    assign s555 = addr[10:0] == 11'h555;
    assign wr_e = we_n && !we_q && !ce_n && oe_n;
    assign rdy = busy_r == 8'h00;
    initial
    begin
        user_r = '{4{16'hffff}};
        locked_r = 1'b0;
    end
////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        we_q <= we_n;
        oe_q <= oe_n;
        if (busy_r != 8'h00)
            busy_r <= busy_r - 8'h01;
        if (busy_r != 8'h00 && oe_n && !oe_q)
            tog_r <= ~tog_r;
        if (!ce_n && !oe_n)
            held_r <= rd;
        if (rst)
        begin
            {ident_r, query_r, prog_r, step_r} <= '0;
            pwr_r <= 0;
            busy_r <= 8'h00;
            tog_r <= 1'b0;
        end
        else if (pwr_r < PWR_CLKS)
            pwr_r <= pwr_r + 1;
        if (!rst && wr_e)
        begin
            step_r <= 2'd0;
            prog_r <= 1'b0;
            if (prog_r && addr == 19'h80)
                locked_r <= locked_r | ~dq[1];
            // only user words, never factory ones
            else if (prog_r && !locked_r && pwr_r >= PWR_CLKS
                     && addr >= 19'h85 && addr <= 19'h88)
            begin
                user_r[a[1:0] - 2'd1] <= dq;
                last_r <= dq;
                busy_r <= busy_len;
            end
            if (prog_r)
                ;
            else if (d == 8'hf0)
                {ident_r, query_r} <= 2'b00;
            else if (addr[11:0] == 12'h055 && d == 8'h98)
                query_r <= 1'b1;
            else if (step_r == 2'd0 && s555 && d == 8'haa)
                step_r <= 2'd1;
            else if (step_r == 2'd1 && addr[10:0] == 11'h2aa && d == 8'h55)
                step_r <= 2'd2;
            else if (step_r == 2'd2 && s555 && d == 8'h90)
                ident_r <= 1'b1;
            else if (step_r == 2'd2 && s555 && d == 8'hc0)
                prog_r <= 1'b1;
        end
    end
////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // status config stays at its power-up value 00
        if (busy_r != 8'h00)
            rd = {8'h00, ~last_r[7], tog_r, 3'b000, 1'b1, 2'b00};
        else if (query_r)
            rd = 16'h0051;
        else if (ident_r && addr == 19'h80)
            rd = {14'h0000, ~locked_r, 1'b0};
        else if (ident_r && addr >= 19'h81 && addr <= 19'h84)
            rd = FACTORY[(a - 8'h81) * 16 +: 16];
        else if (ident_r && addr >= 19'h85 && addr <= 19'h88)
            rd = user_r[a[1:0] - 2'd1];
        else
            rd = 16'hffff;
    end
    assign dq_out = (!ce_n && !oe_n) ? rd : ~held_r;
endmodule

/* verif/tb.sv */
// Purpose: self-checking bench for the security register host
// Assumes: device model stands on the flash pins
// Notes: every op leaves one note, checked at its response pulse
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    localparam logic [63:0] FACT = 64'h5a3c96e10f872b4d;
    typedef struct {logic [1:0] k; logic [127:0] v;} note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [1:0] cmd_word = 2'h0;
    logic [15:0] cmd_data = 16'h0000;
    logic [7:0] busy_len = 8'h00;
    logic cmd_ready, rsp_valid, rsp_locked, rdy, ce_n, oe_n, we_n, dq_oe_n;
    logic [15:0] rsp_data, dq_o, dq_in, dev_dq;
    logic [15:0] exp_u [4];
    logic [127:0] sec_data;
    logic dev_busy;
    logic [18:0] fl_addr;
    note_t notes [$];
    note_t n;
    int errors = 0;
    int n_compared = 0;
////////////////////////////////////////////////////////////////////////////
    flash_sec_host #(.POWERUP_CYCLES(10)) flash_sec_host_inst (
        .CLOCK(clk), .SYS_RST(rst), .CMD_VALID(cmd_valid),
        .CMD_OP(cmd_op), .CMD_WORD(cmd_word), .CMD_DATA(cmd_data),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_LOCKED(rsp_locked),
        .SEC_DATA(sec_data), .READY_BUSY_IN(rdy), .DEV_BUSY(dev_busy),
        .FL_ADDR(fl_addr), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
        .FL_WE_N(we_n), .FL_DQ_IN(dq_in), .FL_DQ_OUT(dq_o),
        .FL_DQ_OE_N(dq_oe_n));
    flash_dev_model #(.FACTORY(FACT)) flash_dev_model_inst (
        .clk(clk), .rst(rst), .busy_len(busy_len), .addr(fl_addr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq_in),
        .dq_out(dev_dq), .rdy(rdy));
    assign dq_in = !dq_oe_n ? dq_o : dev_dq;
    initial
        forever #25 clk = ~clk;
////////////////////////////////////////////////////////////////////////////
    function automatic logic [127:0] sec_exp();
        return {exp_u[3], exp_u[2], exp_u[1], exp_u[0], FACT};
    endfunction
    task automatic run(input logic [2:0] op, input logic [1:0] w,
                       input logic [15:0] d, input logic [1:0] k,
                       input logic [127:0] v);
        int t;
        t = 0;
        @(posedge clk);
        while (cmd_ready !== 1'b1 && t < 400)
        begin
            @(posedge clk);
            t++;
        end
        if (t >= 400)
            errors++;
        notes.push_back('{k, v});
        cmd_op <= op;
        cmd_word <= w;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        t = 0;
        while (rsp_valid !== 1'b1 && t < 2000)
        begin
            @(posedge clk);
            t++;
        end
        if (t >= 2000)
            errors++;
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (rsp_valid === 1'b1)
        begin
            if (notes.size() == 0)
                `CHK("note queue", 1'b1, 1'b0)
            else
            begin
                n = notes.pop_front();
                `CHK("dev_busy", 1'b0, dev_busy)
                if (n.k == 2'd1)
                begin
                    `CHK("sec_data", n.v, sec_data)
                    `CHK("rsp_data", n.v[127:112], rsp_data)
                end
                else if (n.k == 2'd2)
                begin
                    `CHK("rsp_locked", n.v[0], rsp_locked)
                    `CHK("lock_bit", !n.v[0], rsp_data[1])
                end
            end
        end
    initial
    begin
        repeat (10000) @(posedge clk);
        errors++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(4));
        exp_u = '{4{16'hffff}};
        do_reset();
        run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        $display("test blank_read done");
        for (int i = 0; i < 4; i++)
        begin
            exp_u[i] = 16'($urandom);
            busy_len <= 8'($urandom_range(40, 1));
            run(3'd1, 2'(i), exp_u[i], 2'd0, '0);
        end
        run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        $display("test program done");
        run(3'd3, 2'd0, 16'h0, 2'd2, 128'h0);
        run(3'd2, 2'd0, 16'h0, 2'd0, 128'h0);
        run(3'd3, 2'd0, 16'h0, 2'd2, 128'h1);
        run(3'd1, 2'd2, 16'h1234, 2'd0, 128'h0);
        run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        $display("test lock done");
        run(3'd4, 2'd0, 16'h0, 2'd0, 128'h0);
        run(3'd0, 2'd0, 16'h0, 2'd1, {8{16'h0051}});
        run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        for (int i = 5; i < 7; i++)
        begin
            run(3'd4, 2'd0, 16'h0, 2'd0, 128'h0);
            run(3'(i), 2'd0, 16'h0, 2'd0, 128'h0);
            run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        end
        $display("test query done");
        run(3'd4, 2'd0, 16'h0, 2'd0, 128'h0);
        do_reset();
        run(3'd0, 2'd0, 16'h0, 2'd1, sec_exp());
        $display("test reset done");
        report_and_stop();
    end
endmodule
